// [rtl/uoe_out_ep0_control.sv]
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
// How it works
// - enable bit 31 set by software only, cleared by the core only
// - disable bit 30 reads zero; writes ignored
// - writing one to bit 27 sets nak state
// - writing one to bit 26 clears nak state
// - stall bit 21 set makes OUT transactions answered with STALL
// - core clears stall bit when a SETUP token arrives
// - stall beats nak when both set
// - snoop bit 20 set skips data CRC check
// - transfer type bits 19:18 read fixed 00, control
// - nak state only matters when stall and global out nak clear
// - nak state zero: answer follows enable bit and receive FIFO state
// - nak state one: every OUT token gets NAK
// - nak state read-only; changed only through set and clear strobes
// - active bit 15 always reads one
// - max packet size bits 1:0 mirror IN endpoint 0 field
// - register at 0xb00, reset value 0x00008000
module uoe_out_ep0_control
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // core side events and status
    input wire logic setup_rcvd_i,
    input wire logic ep_done_i,
    input wire logic global_out_nak_state_i,
    input wire logic [1:0] in_ep0_max_packet_size_i,
    // out token decision
    input wire logic out_token_i,
    input wire logic fifo_room_i,
    output uoe_pkg::uoe_resp_e resp_o,
    output logic resp_valid_o,
    // steering outputs
    output logic endpoint_on_o,
    output logic stall_o,
    output logic nak_state_o,
    output logic crc_check_en_o
);

    logic wr_hit;
    logic rd_hit;
    logic endpoint_on_q;
    logic stall_q;
    logic snoop_q;
    logic nak_state_q;
    uoe_pkg::uoe_resp_e resp_d;
    uoe_pkg::uoe_resp_e resp_q;
    logic resp_valid_q;
    logic [31:0] rd_word;

    // single-cycle access phase, unmapped addresses error
    assign wr_hit = psel_i && penable_i && pwrite_i && (paddr_i == uoe_pkg::OUT_EP0_CONTROL_ADDR);
    assign rd_hit = paddr_i == uoe_pkg::OUT_EP0_CONTROL_ADDR;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !rd_hit;

    // enable: software sets, core clears at end of transfer
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            endpoint_on_q <= 1'b0;
        else if (wr_hit && pwdata_i[uoe_pkg::ENDPOINT_ON_BIT])
            endpoint_on_q <= 1'b1;
        else if (ep_done_i)
            endpoint_on_q <= 1'b0;
    end

    // stall: setup clear is the hardware event, so it wins over a software set
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            stall_q <= 1'b0;
        else if (setup_rcvd_i)
            stall_q <= 1'b0;
        else if (wr_hit && pwdata_i[uoe_pkg::STALL_BIT])
            stall_q <= 1'b1;
    end

    // snoop mode is plain read/write
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            snoop_q <= 1'b0;
        else if (wr_hit)
            snoop_q <= pwdata_i[uoe_pkg::SNOOP_BIT];
    end

    // nak state only through strobes; set wins if both written
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            nak_state_q <= 1'b0;
        else if (wr_hit && pwdata_i[uoe_pkg::FORCE_NAK_SET_BIT])
            nak_state_q <= 1'b1;
        else if (wr_hit && pwdata_i[uoe_pkg::FORCE_NAK_CLEAR_BIT])
            nak_state_q <= 1'b0;
    end

    // answer priority: stall, then global nak, then local nak, then fifo
    always_comb
    begin
        resp_d = uoe_pkg::UOE_RESP_NONE;
        if (stall_q)
            resp_d = uoe_pkg::UOE_RESP_STALL;
        else if (global_out_nak_state_i || nak_state_q)
            resp_d = uoe_pkg::UOE_RESP_NAK;
        else if (endpoint_on_q && fifo_room_i)
            resp_d = uoe_pkg::UOE_RESP_DATA;
        else
            resp_d = uoe_pkg::UOE_RESP_NAK;
    end

    // answer registered one cycle after the token
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            resp_q <= uoe_pkg::UOE_RESP_NONE;
            resp_valid_q <= 1'b0;
        end
        else
        begin
            resp_q <= out_token_i ? resp_d : uoe_pkg::UOE_RESP_NONE;
            resp_valid_q <= out_token_i;
        end
    end

    // read word: fixed fields and strobes read as constants
    always_comb
    begin
        rd_word = '0;
        rd_word[uoe_pkg::ENDPOINT_ON_BIT] = endpoint_on_q;
        rd_word[uoe_pkg::ENDPOINT_OFF_REQUEST_BIT] = 1'b0;
        rd_word[uoe_pkg::FORCE_NAK_SET_BIT] = 1'b0;
        rd_word[uoe_pkg::FORCE_NAK_CLEAR_BIT] = 1'b0;
        rd_word[uoe_pkg::STALL_BIT] = stall_q;
        rd_word[uoe_pkg::SNOOP_BIT] = snoop_q;
        rd_word[uoe_pkg::TRANSFER_TYPE_LSB +: 2] = uoe_pkg::TRANSFER_TYPE_CONTROL;
        rd_word[uoe_pkg::NAK_STATE_BIT] = nak_state_q;
        rd_word[uoe_pkg::ENDPOINT_LIVE_BIT] = uoe_pkg::ENDPOINT_LIVE_VALUE;
        rd_word[uoe_pkg::MAX_PACKET_SIZE_LSB +: 2] = in_ep0_max_packet_size_i;
    end

    // read data registered at setup so it is stable in the access phase
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            prdata_o <= 32'h0000_0000;
        else if (psel_i && !penable_i && !pwrite_i)
            prdata_o <= rd_hit ? rd_word : 32'h0000_0000;
    end

    assign resp_o = resp_q;
    assign resp_valid_o = resp_valid_q;
    assign endpoint_on_o = endpoint_on_q;
    assign stall_o = stall_q;
    assign nak_state_o = nak_state_q;
    assign crc_check_en_o = !snoop_q;

    // assertions; multi-step checks other than a_quiet_no_token and a_nak_holds are built from the named sequences below
    // write access that lands on this register
    sequence s_ctl_write;
        psel_i && penable_i && pwrite_i && rd_hit;
    endsequence

    // read access phase on this register; data was captured at setup
    sequence s_ctl_read;
        psel_i && penable_i && !pwrite_i && rd_hit;
    endsequence

    // out token that needs an answer next cycle
    sequence s_out_token;
        out_token_i;
    endsequence

    // setup token seen on this endpoint
    sequence s_setup_seen;
        setup_rcvd_i;
    endsequence

    // setup always drops stall, even against a software set
    a_stall_on_setup_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_setup_seen
        |=> !stall_q)
        else $error("stall not cleared by setup");

    // software has no way to clear stall
    a_stall_fell_setup: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        $fell(stall_q)
        |-> $past(setup_rcvd_i))
        else $error("stall cleared without setup");

    // stall only rises through a register write
    a_stall_rose_write: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        $rose(stall_q)
        |-> ($past(wr_hit) && $past(pwdata_i[uoe_pkg::STALL_BIT])))
        else $error("stall set without write");

    // stall answers every out token
    a_stall_wins_nak: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_out_token ##0 stall_q
        |=> resp_o == uoe_pkg::UOE_RESP_STALL)
        else $error("stall lost");

    // stall beats a pending nak
    a_stall_over_nak: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_out_token ##0 (stall_q && nak_state_q)
        |=> resp_o == uoe_pkg::UOE_RESP_STALL)
        else $error("nak beat stall");

    // local nak answers when stall is clear
    a_nak_forced: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_out_token ##0 (!stall_q && nak_state_q)
        |=> resp_o == uoe_pkg::UOE_RESP_NAK)
        else $error("nak not sent");

    // global nak overrides local state
    a_global_nak_sent: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_out_token ##0 (!stall_q && global_out_nak_state_i)
        |=> resp_o == uoe_pkg::UOE_RESP_NAK)
        else $error("global nak ignored");

    // free path with room gives data
    a_data_when_free: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_out_token ##0 (!stall_q && !global_out_nak_state_i && !nak_state_q && endpoint_on_q && fifo_room_i)
        |=> resp_o == uoe_pkg::UOE_RESP_DATA)
        else $error("data answer missing");

    // free path without room or enable gives nak
    a_nak_when_full: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_out_token ##0 (!stall_q && !global_out_nak_state_i && !nak_state_q && !(endpoint_on_q && fifo_room_i))
        |=> resp_o == uoe_pkg::UOE_RESP_NAK)
        else $error("full fifo not refused");

    // every token gets exactly one answer cycle
    a_answer_valid: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_out_token
        |=> resp_valid_o)
        else $error("answer missing");

    // no answer without a token
    a_quiet_no_token: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        !out_token_i
        |=> (!resp_valid_o && resp_o == uoe_pkg::UOE_RESP_NONE))
        else $error("answer without token");

    // set strobe takes effect next edge
    a_nak_set_strobe: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_ctl_write ##0 pwdata_i[uoe_pkg::FORCE_NAK_SET_BIT]
        |=> nak_state_q)
        else $error("nak set failed");

    // clear strobe alone takes effect next edge
    a_nak_clear_strobe: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_ctl_write ##0 (!pwdata_i[uoe_pkg::FORCE_NAK_SET_BIT] && pwdata_i[uoe_pkg::FORCE_NAK_CLEAR_BIT])
        |=> !nak_state_q)
        else $error("nak clear failed");

    // nak state never moves without a strobe
    a_nak_holds: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        !(wr_hit && (pwdata_i[uoe_pkg::FORCE_NAK_SET_BIT] || pwdata_i[uoe_pkg::FORCE_NAK_CLEAR_BIT]))
        |=> $stable(nak_state_q))
        else $error("nak changed without strobe");

    // nak state is visible on read
    a_nak_readback: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_ctl_read ##0 $stable(nak_state_q)
        |-> prdata_o[uoe_pkg::NAK_STATE_BIT] == nak_state_q)
        else $error("nak readback wrong");

    // snoop bit reads back what was written
    a_snoop_readback: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_ctl_read ##0 $stable(snoop_q)
        |-> prdata_o[uoe_pkg::SNOOP_BIT] == snoop_q)
        else $error("snoop readback wrong");

    // crc check follows the written snoop bit, not just the flop
    a_crc_follows_snoop: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_ctl_write
        |=> crc_check_en_o == !$past(pwdata_i[uoe_pkg::SNOOP_BIT]))
        else $error("crc check mismatch");

    // enable only rises through a software write of one
    a_enable_set_only_sw: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        $rose(endpoint_on_q)
        |-> ($past(wr_hit) && $past(pwdata_i[uoe_pkg::ENDPOINT_ON_BIT])))
        else $error("enable set without write");

    // enable only falls through the core
    a_enable_clear_core: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        $fell(endpoint_on_q)
        |-> $past(ep_done_i))
        else $error("enable cleared by software");

    // enable is visible on read
    a_enable_readback: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_ctl_read ##0 $stable(endpoint_on_q)
        |-> prdata_o[uoe_pkg::ENDPOINT_ON_BIT] == endpoint_on_q)
        else $error("enable readback wrong");

    // disable request has no storage here
    a_off_request_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_ctl_read
        |-> !prdata_o[uoe_pkg::ENDPOINT_OFF_REQUEST_BIT])
        else $error("disable bit not zero");

    // endpoint type is fixed to control
    a_type_control: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_ctl_read
        |-> prdata_o[uoe_pkg::TRANSFER_TYPE_LSB +: 2] == uoe_pkg::TRANSFER_TYPE_CONTROL)
        else $error("type field wrong");

    // both strobes read as zero
    a_strobes_read_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_ctl_read
        |-> (!prdata_o[uoe_pkg::FORCE_NAK_SET_BIT] && !prdata_o[uoe_pkg::FORCE_NAK_CLEAR_BIT]))
        else $error("strobe reads one");

    // active bit always one on this endpoint
    a_fixed_fields: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_ctl_read
        |-> prdata_o[uoe_pkg::ENDPOINT_LIVE_BIT] == uoe_pkg::ENDPOINT_LIVE_VALUE)
        else $error("fixed field wrong");

    // packet size mirrors the in endpoint field
    a_mps_mirror: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s_ctl_read ##0 $stable(in_ep0_max_packet_size_i)
        |-> prdata_o[uoe_pkg::MAX_PACKET_SIZE_LSB +: 2] == in_ep0_max_packet_size_i)
        else $error("packet size not mirrored");

    // only the one offset is mapped
    a_map_error: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (psel_i && penable_i && paddr_i != uoe_pkg::OUT_EP0_CONTROL_ADDR)
        |-> pslverr_o)
        else $error("unmapped access not refused");

endmodule

// [rtl/uoe_pkg.sv]
package uoe_pkg;
    // register map
    localparam logic [11:0] OUT_EP0_CONTROL_ADDR = 12'hb00;
    localparam logic [31:0] OUT_EP0_CONTROL_RESET = 32'h0000_8000;
    // field positions
    localparam int ENDPOINT_ON_BIT = 31;
    localparam int ENDPOINT_OFF_REQUEST_BIT = 30;
    localparam int FORCE_NAK_SET_BIT = 27;
    localparam int FORCE_NAK_CLEAR_BIT = 26;
    localparam int STALL_BIT = 21;
    localparam int SNOOP_BIT = 20;
    localparam int TRANSFER_TYPE_LSB = 18;
    localparam int NAK_STATE_BIT = 17;
    localparam int ENDPOINT_LIVE_BIT = 15;
    localparam int MAX_PACKET_SIZE_LSB = 0;
    // fixed field values
    localparam logic [1:0] TRANSFER_TYPE_CONTROL = 2'h0;
    localparam logic ENDPOINT_LIVE_VALUE = 1'b1;
    // handshake answer codes
    typedef enum logic [1:0]
    {
        UOE_RESP_NONE,
        UOE_RESP_DATA,
        UOE_RESP_NAK,
        UOE_RESP_STALL
    } uoe_resp_e;
endpackage

// [verif/uoe_host_model.sv]
`timescale 1ns/100ps
// usb host side: issues OUT and SETUP tokens as one-cycle pulses
module uoe_host_model
(
    // clock
    input wire logic sys_clk_i,
    // token pulses toward the endpoint logic
    output logic out_token_o,
    output logic setup_rcvd_o
);
    // idle low so no token is seen before the first request
    initial
    begin
        out_token_o = 1'b0;
        setup_rcvd_o = 1'b0;
    end
    // one token per call; pulse lasts exactly one cycle
    task automatic send(input logic setup);
        @(posedge sys_clk_i);
        out_token_o <= ~setup;
        setup_rcvd_o <= setup;
        @(posedge sys_clk_i);
        out_token_o <= 1'b0;
        setup_rcvd_o <= 1'b0;
    endtask
endmodule

// [verif/testbench.sv]
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_fail++; \
    $display("FAIL %s exp %h got %h", nm, ex, got); end end
module testbench;
    localparam logic [11:0] A = 12'hb00;
    logic sys_clk_i, rst_b_i, psel, penable, pwrite, ep_done, gnak, fifo_room;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata_o;
    logic [1:0] mps;
    logic pready_o, pslverr_o, out_token, setup_rcvd, resp_valid_o, crc_check_en_o;
    logic endpoint_on_o, stall_o, nak_state_o;
    uoe_pkg::uoe_resp_e resp_o;
    int checks = 0;
    int n_fail = 0;
    uoe_out_ep0_control uoe_out_ep0_control_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .setup_rcvd_i(setup_rcvd),
        .ep_done_i(ep_done), .global_out_nak_state_i(gnak), .in_ep0_max_packet_size_i(mps),
        .out_token_i(out_token), .fifo_room_i(fifo_room), .resp_o(resp_o), .resp_valid_o(resp_valid_o),
        .endpoint_on_o(endpoint_on_o), .stall_o(stall_o), .nak_state_o(nak_state_o),
        .crc_check_en_o(crc_check_en_o));
    uoe_host_model uoe_host_model_inst (.sys_clk_i(sys_clk_i), .out_token_o(out_token),
        .setup_rcvd_o(setup_rcvd));
    // 40 MHz clock
    initial
    begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    task automatic test_done;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one apb transfer; an edge passes first so strobes never change twice in a step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        int n;
        @(posedge sys_clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            n_fail++;
            test_done();
        end
        q = prdata_o;
        e = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] ex, input logic exe);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        `CHK("read", ex, q);
        `CHK("slverr", exe, e);
    endtask
    // token answer is due exactly one cycle after the token edge
    task automatic tok(input uoe_pkg::uoe_resp_e x);
        uoe_host_model_inst.send(1'b0);
        #1;
        `CHK("resp_valid", 1'b1, resp_valid_o);
        `CHK("resp", x, resp_o);
    endtask
    // main sequence
    initial
    begin
        rst_b_i = 1'b0;
        {psel, penable, pwrite, ep_done, gnak} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        mps = 2'h0;
        fifo_room = 1'b1;
        repeat (8) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            mps <= 2'(i);
            rd(A, 32'h0000_8000 | i, 1'b0);
        end
        wr(A, 32'hffff_ffff);
        rd(A, 32'h8032_8003, 1'b0);
        `CHK("crc_en", 1'b0, crc_check_en_o);
        `CHK("endpoint_on", 1'b1, endpoint_on_o);
        `CHK("stall", 1'b1, stall_o);
        `CHK("nak_state", 1'b1, nak_state_o);
        gnak <= 1'b1;
        tok(uoe_pkg::UOE_RESP_STALL);
        uoe_host_model_inst.send(1'b1);
        rd(A, 32'h8012_8003, 1'b0);
        `CHK("stall", 1'b0, stall_o);
        tok(uoe_pkg::UOE_RESP_NAK);
        wr(A, 32'h0400_0000);
        rd(A, 32'h8000_8003, 1'b0);
        `CHK("crc_en", 1'b1, crc_check_en_o);
        tok(uoe_pkg::UOE_RESP_NAK);
        gnak <= 1'b0;
        tok(uoe_pkg::UOE_RESP_DATA);
        fifo_room <= 1'b0;
        tok(uoe_pkg::UOE_RESP_NAK);
        wr(A, 32'h0002_0000);
        rd(A, 32'h8000_8003, 1'b0);
        wr(A, 32'h0800_0000);
        wr(A, 32'h0);
        rd(A, 32'h8002_8003, 1'b0);
        @(posedge sys_clk_i);
        ep_done <= 1'b1;
        @(posedge sys_clk_i);
        ep_done <= 1'b0;
        rd(A, 32'h0002_8003, 1'b0);
        `CHK("endpoint_on", 1'b0, endpoint_on_o);
        wr(A + 12'h4, 32'hffff_ffff);
        rd(A + 12'h4, 32'h0, 1'b1);
        rd(A, 32'h0002_8003, 1'b0);
        test_done();
    end
endmodule
